// file: rtl/dsreg_top.sv
// Status, error counter, loop driver and attenuator register slice
//
// Behaviour
// RQ1 - Read-only 3-bit rate band; 010..110 name bands, 111 means no lock
// RQ2 - Two-bit self-test result: pass, lead-in miss, pattern or sequence fail
// RQ3 - Self-test done flag set on pattern end only outside repeat mode
// RQ4 - Read-only flag shows self-test data alignment finished
// RQ5 - Eight-bit read-only count of link-loss events, zero at reset
// RQ6 - Sixteen-bit data error count, low byte then high byte, zero at reset
// RQ7 - Writable 3-bit amplitude selects one of eight levels, reset 011
// RQ8 - Two override bits take attenuation away from automatic control
// RQ9 - Attenuator enable honoured only while its override is set
// RQ10 - One select bit picks recovery or data counter for reading
`timescale 1ns/100ps
module dsreg_top #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Status inputs from the receiver
    input  wire logic       lock_valid,
    input  wire logic [2:0] rate_band,
    input  wire logic       clock_recovery_event,
    input  wire logic       data_error,
    input  wire logic       count_clear,
    // Self-test status inputs
    input  wire logic [1:0] built_in_self_test_result,
    input  wire logic       built_in_self_test_pat_end,
    input  wire logic       built_in_self_test_repeat,
    input  wire logic       built_in_self_test_start,
    input  wire logic       built_in_self_test_aligned,
    // Control outputs and automatic attenuator enable inputs
    output logic            loop_term_50,
    output logic      [2:0] loop_amplitude,
    output logic            eq0_att_override,
    output logic            eq1_att_override,
    output logic            eq0_att_enable,
    output logic            eq1_att_enable,
    input  wire logic       eq0_att_auto,
    input  wire logic       eq1_att_auto
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0]       rate_ff;
    logic [1:0]       st_res_ff;
    logic             st_done_ff;
    logic             st_align_ff;
    logic             term_ff;
    logic [2:0]       amp_ff;
    logic [3:0]       att_ff;
    logic             evt_sel_ff;
    logic [CNT_W-1:0] recov_cnt;
    logic [CNT_W-1:0] data_evt_cnt;
    logic [15:0]      derr_cnt;
    logic [7:0]       nxt_rdata;

    // RQ1 rate band capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_ff <= dsreg_pkg::RATE_NO_LOCK;
        end else if (lock_valid && rate_band >= dsreg_pkg::RATE_BAND_MIN
                     && rate_band <= dsreg_pkg::RATE_BAND_MAX) begin
            rate_ff <= rate_band;
        end else begin
            rate_ff <= dsreg_pkg::RATE_NO_LOCK;
        end
    end

    // Start of a new run clears the flags; a completion event beats it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_res_ff   <= dsreg_pkg::ST_PASS;
            st_done_ff  <= 1'b0;
            st_align_ff <= 1'b0;
        end else begin
            // RQ2 self-test result
            st_res_ff <= built_in_self_test_result;
            // RQ3 done outside repeat
            if (built_in_self_test_pat_end && !built_in_self_test_repeat) begin
                st_done_ff <= 1'b1;
            end else if (built_in_self_test_start) begin
                st_done_ff <= 1'b0;
            end
            // RQ4 alignment flag
            if (built_in_self_test_aligned) begin
                st_align_ff <= 1'b1;
            end else if (built_in_self_test_start) begin
                st_align_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RQ5 link-loss event counter
    dsreg_counter #(.WIDTH(CNT_W)) u_recov_cnt (
        .sys_clk (sys_clk),
        .rst     (rst),
        .inc     (clock_recovery_event),
        .clr     (count_clear),
        .count   (recov_cnt)
    );

    dsreg_counter #(.WIDTH(CNT_W)) u_data_evt_cnt (
        .sys_clk (sys_clk),
        .rst     (rst),
        .inc     (data_error),
        .clr     (count_clear),
        .count   (data_evt_cnt)
    );

    // RQ6 sixteen-bit data error count
    dsreg_counter #(.WIDTH(16)) u_derr_cnt (
        .sys_clk (sys_clk),
        .rst     (rst),
        .inc     (data_error),
        .clr     (count_clear),
        .count   (derr_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // RQ7 loop driver config write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            term_ff <= dsreg_pkg::TERM_RESET;
            amp_ff  <= dsreg_pkg::AMP_RESET;
        end else if (reg_wr && reg_addr == dsreg_pkg::ADDR_LOOP_CFG) begin
            term_ff <= reg_wdata[dsreg_pkg::LOOP_TERM_BIT];
            amp_ff  <= reg_wdata[dsreg_pkg::LOOP_AMP_LSB +: 3];
        end
    end

    // RQ8 override and enable bits write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            att_ff <= 4'h0;
        end else if (reg_wr && reg_addr == dsreg_pkg::ADDR_EQ_ATTEN) begin
            att_ff <= reg_wdata[3:0];
        end
    end

    // RQ10 counter select write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            evt_sel_ff <= 1'b0;
        end else if (reg_wr && reg_addr == dsreg_pkg::ADDR_EVT_CFG) begin
            evt_sel_ff <= reg_wdata[dsreg_pkg::EVT_SEL_BIT];
        end
    end

    assign loop_term_50     = term_ff;
    assign loop_amplitude   = amp_ff;
    assign eq0_att_override = att_ff[dsreg_pkg::ATT0_OVR_BIT];
    assign eq1_att_override = att_ff[dsreg_pkg::ATT1_OVR_BIT];

    // RQ9 enable gated by override
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eq0_att_enable <= 1'b0;
            eq1_att_enable <= 1'b0;
        end else begin
            eq0_att_enable <= att_ff[dsreg_pkg::ATT0_OVR_BIT]
                ? att_ff[dsreg_pkg::ATT0_EN_BIT] : eq0_att_auto;
            eq1_att_enable <= att_ff[dsreg_pkg::ATT1_OVR_BIT]
                ? att_ff[dsreg_pkg::ATT1_EN_BIT] : eq1_att_auto;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = dsreg_pkg::ZERO_BYTE;
        case (reg_addr)
            dsreg_pkg::ADDR_RATE_STAT: begin
                nxt_rdata = {1'b0, rate_ff, st_res_ff,
                             st_done_ff, st_align_ff};
            end
            // RQ10 counter read select
            dsreg_pkg::ADDR_LINK_LOSS: begin
                nxt_rdata = evt_sel_ff ? 8'(data_evt_cnt) : 8'(recov_cnt);
            end
            dsreg_pkg::ADDR_DERR_LO:  nxt_rdata = derr_cnt[7:0];
            dsreg_pkg::ADDR_DERR_HI:  nxt_rdata = derr_cnt[15:8];
            dsreg_pkg::ADDR_LOOP_CFG: begin
                nxt_rdata = {3'h0, term_ff, amp_ff, 1'b0};
            end
            dsreg_pkg::ADDR_EQ_ATTEN: nxt_rdata = {4'h0, att_ff};
            dsreg_pkg::ADDR_EVT_CFG:  nxt_rdata = {4'h0, evt_sel_ff, 3'h0};
            default:                  nxt_rdata = dsreg_pkg::ZERO_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= dsreg_pkg::ZERO_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_loop_write;
        reg_wr && reg_addr == dsreg_pkg::ADDR_LOOP_CFG;
    endsequence

    a_rate_no_lock: assert property ( // RQ1
        @(posedge sys_clk) disable iff (rst)
        !lock_valid |=> rate_ff == dsreg_pkg::RATE_NO_LOCK)
        else $error("rate not no-lock while unlocked");
    a_rate_band: assert property ( // RQ1
        @(posedge sys_clk) disable iff (rst)
        lock_valid && rate_band == 3'h4 |=> rate_ff == 3'h4)
        else $error("rate band not captured");
    a_selftest_result: assert property ( // RQ2
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> st_res_ff == $past(built_in_self_test_result))
        else $error("self-test result not tracked");
    a_done_repeat: assert property ( // RQ3
        @(posedge sys_clk) disable iff (rst)
        !st_done_ff && built_in_self_test_repeat |=> !st_done_ff)
        else $error("done set in repeat mode");
    a_done_set: assert property ( // RQ3
        @(posedge sys_clk) disable iff (rst)
        built_in_self_test_pat_end && !built_in_self_test_repeat
        |=> st_done_ff [*1])
        else $error("done not set");
    a_align_set: assert property ( // RQ4
        @(posedge sys_clk) disable iff (rst)
        built_in_self_test_aligned |=> st_align_ff)
        else $error("align flag not set");
    a_recov_count: assert property ( // RQ5
        @(posedge sys_clk) disable iff (rst)
        clock_recovery_event && recov_cnt < 8'hFF
        |=> recov_cnt == $past(recov_cnt) + 8'h01)
        else $error("link-loss count not incremented");
    a_derr_count: assert property ( // RQ6
        @(posedge sys_clk) disable iff (rst)
        !data_error && !count_clear |=> $stable(derr_cnt))
        else $error("data error count moved without error");
    a_amp_write: assert property ( // RQ7
        @(posedge sys_clk) disable iff (rst)
        s_loop_write |=> loop_amplitude == $past(reg_wdata[3:1]))
        else $error("amplitude write lost");
    a_att_gate: assert property ( // RQ9
        @(posedge sys_clk) disable iff (rst)
        !eq0_att_override && $stable(eq0_att_override)
        |=> eq0_att_enable == $past(eq0_att_auto))
        else $error("enable honoured without override");
    a_att_ovr: assert property ( // RQ8
        @(posedge sys_clk) disable iff (rst)
        eq1_att_override && $stable(att_ff)
        |=> eq1_att_enable == $past(att_ff[0]))
        else $error("override not taking control");
    a_cnt_select: assert property ( // RQ10
        @(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == dsreg_pkg::ADDR_LINK_LOSS && evt_sel_ff
        |=> reg_rdata == $past(data_evt_cnt))
        else $error("counter select wrong");
endmodule

// file: rtl/dsreg_pkg.sv
// Register map, field layout and encodings of the status and loop registers
package dsreg_pkg;
    localparam logic [7:0] ADDR_RATE_STAT  = 8'h3B;
    localparam logic [7:0] ADDR_LINK_LOSS  = 8'h3D;
    localparam logic [7:0] ADDR_DERR_LO    = 8'h3E;
    localparam logic [7:0] ADDR_DERR_HI    = 8'h3F;
    localparam logic [7:0] ADDR_LOOP_CFG   = 8'h49;
    localparam logic [7:0] ADDR_EQ_ATTEN   = 8'h60;
    localparam logic [7:0] ADDR_EVT_CFG    = 8'h2B;

    localparam logic [2:0] RATE_NO_LOCK    = 3'h7;
    localparam logic [2:0] RATE_BAND_MIN   = 3'h2;
    localparam logic [2:0] RATE_BAND_MAX   = 3'h6;
    localparam logic [1:0] ST_PASS         = 2'h0;
    localparam logic [1:0] ST_NO_LEAD_IN   = 2'h1;
    localparam logic [1:0] ST_PAT_FAIL     = 2'h2;
    localparam logic [1:0] ST_SEQ_FAIL     = 2'h3;

    localparam logic [2:0] AMP_RESET       = 3'h3;
    localparam logic       TERM_RESET      = 1'h1;
    localparam int         LOOP_TERM_BIT   = 4;
    localparam int         LOOP_AMP_LSB    = 1;
    localparam int         ATT0_OVR_BIT    = 3;
    localparam int         ATT1_OVR_BIT    = 2;
    localparam int         ATT0_EN_BIT     = 1;
    localparam int         ATT1_EN_BIT     = 0;
    localparam int         EVT_SEL_BIT     = 3;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
endpackage

// file: rtl/dsreg_counter.sv
// Saturating event counter with synchronous clear
`timescale 1ns/100ps
module dsreg_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Control
    input  wire logic             inc,
    input  wire logic             clr,
    // Count
    output logic      [WIDTH-1:0] count
);
    // Saturation keeps a flooded link from wrapping to a small value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (inc) begin
            // A saturated count holds; an event still beats a clear
            if (!(&count)) begin
                count <= count + 1'b1;
            end
        end else if (clr) begin
            count <= '0;
        end
    end
endmodule

// file: testbench/dsreg_top_tb.sv
// Self-checking bench for the status, counter, loop and attenuator registers
`timescale 1ns/100ps
module dsreg_top_tb;
    logic       sys_clk, rst, reg_wr, reg_rd, lock_valid, crev, derr, clr;
    logic [7:0] reg_addr, reg_wdata;
    logic [7:0] reg_rdata;
    logic [2:0] rate_band;
    logic [1:0] res;
    logic       pend, rpt, start, algn, auto0, auto1;
    logic       term, ov0, ov1, en0, en1;
    logic [2:0] amp;
    logic [2:0] er;
    int         fails, n_checks;

    dsreg_top u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .lock_valid(lock_valid), .rate_band(rate_band),
        .clock_recovery_event(crev), .data_error(derr), .count_clear(clr),
        .built_in_self_test_result(res), .built_in_self_test_pat_end(pend),
        .built_in_self_test_repeat(rpt), .built_in_self_test_start(start),
        .built_in_self_test_aligned(algn), .loop_term_50(term),
        .loop_amplitude(amp), .eq0_att_override(ov0), .eq1_att_override(ov1),
        .eq0_att_enable(en0), .eq1_att_enable(en1), .eq0_att_auto(auto0),
        .eq1_att_auto(auto1));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands from the taking edge, so it is compared one edge on
    task automatic rd(input logic [7:0] a, e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(posedge sys_clk);
        chk($sformatf("addr_%h", a), reg_rdata, e);
    endtask

    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        report_and_stop;
    end

    initial begin
        {rst, reg_wr, reg_rd, lock_valid, crev, derr, clr} = 7'h40;
        {reg_addr, reg_wdata, rate_band, res} = '0;
        {pend, rpt, start, algn, auto0, auto1} = '0;
        fails = 0;
        n_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h3B, 8'h70);
        rd(8'h3D, 8'h00);
        rd(8'h3E, 8'h00);
        rd(8'h3F, 8'h00);
        rd(8'h49, 8'h16);
        rd(8'h60, 8'h00);
        rd(8'h50, 8'h00);
        // Every band code, each paired with the self-test result code of its two low bits
        lock_valid <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rate_band <= i[2:0];
            res <= i[1:0];
            er = (i >= 2 && i <= 6) ? i[2:0] : 3'h7;
            rd(8'h3B, {1'b0, er, i[1:0], 2'b00});
        end
        lock_valid <= 1'b0;
        res <= 2'h2;
        rpt <= 1'b1;
        @(posedge sys_clk) pend <= 1'b1;
        @(posedge sys_clk) pend <= 1'b0;
        rd(8'h3B, 8'h78);
        rpt <= 1'b0;
        @(posedge sys_clk) pend <= 1'b1;
        @(posedge sys_clk) pend <= 1'b0;
        rd(8'h3B, 8'h7A);
        @(posedge sys_clk) algn <= 1'b1;
        @(posedge sys_clk) algn <= 1'b0;
        rd(8'h3B, 8'h7B);
        @(posedge sys_clk) start <= 1'b1;
        @(posedge sys_clk) start <= 1'b0;
        rd(8'h3B, 8'h78);
        // Counters: three link losses, then 300 data errors in two parts
        repeat (3) begin
            @(posedge sys_clk) crev <= 1'b1;
            @(posedge sys_clk) crev <= 1'b0;
        end
        repeat (5) begin
            @(posedge sys_clk) derr <= 1'b1;
            @(posedge sys_clk) derr <= 1'b0;
        end
        rd(8'h3D, 8'h03);
        wr(8'h2B, 8'h08);
        rd(8'h3D, 8'h05);
        wr(8'h2B, 8'h00);
        rd(8'h3D, 8'h03);
        repeat (295) begin
            @(posedge sys_clk) derr <= 1'b1;
            @(posedge sys_clk) derr <= 1'b0;
        end
        wr(8'h3E, 8'hFF);
        rd(8'h3E, 8'h2C);
        rd(8'h3F, 8'h01);
        @(posedge sys_clk) clr <= 1'b1;
        @(posedge sys_clk) clr <= 1'b0;
        rd(8'h3D, 8'h00);
        rd(8'h3F, 8'h00);
        // Reserved bits of the loop register ignore writes
        for (int i = 0; i < 8; i++) begin
            wr(8'h49, {3'h7, i[0], i[2:0], 1'b1});
            rd(8'h49, {3'h0, i[0], i[2:0], 1'b0});
            chk("amplitude", {5'h0, amp}, {5'h0, i[2:0]});
            chk("term", {7'h0, term}, {7'h0, i[0]});
        end
        // Automatic values differ from the enable bits, so a leak shows
        for (int i = 0; i < 16; i++) begin
            auto0 <= ~i[1];
            auto1 <= ~i[0];
            wr(8'h60, {4'hF, i[3:0]});
            rd(8'h60, {4'h0, i[3:0]});
            chk("overrides", {6'h0, ov0, ov1}, {6'h0, i[3:2]});
            chk("att0", {7'h0, en0}, {7'h0, i[3] ? i[1] : ~i[1]});
            chk("att1", {7'h0, en1}, {7'h0, i[2] ? i[0] : ~i[0]});
        end
        report_and_stop;
    end
endmodule
